// ===== inc/timer_irq_pkg.sv
// Register map, field layout and types for the timer interrupt flag and mask block
package timer_irq_pkg;

    localparam int NUM_TIMERS = 2;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;

    // Register offsets, index 0 is timer 1 and index 1 is timer 3
    localparam logic [ADDR_W-1:0] FLAGS_ADDR [NUM_TIMERS] = '{8'h16, 8'h18};
    localparam logic [ADDR_W-1:0] MASK_ADDR  [NUM_TIMERS] = '{8'h6F, 8'h71};

    // Bit positions shared by the flag and mask registers
    localparam int BIT_OVF     = 0;
    localparam int BIT_CMPA    = 1;
    localparam int BIT_CMPB    = 2;
    localparam int BIT_CAPTURE = 5;

    // Implemented bits; 7:6 and 4:3 read as zero
    localparam logic [DATA_W-1:0] IMPL_BITS = 8'h27;

    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MASK_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_IDLE  = 8'h00;

    // Waveform modes that matter to flag setting
    localparam logic [3:0] MODE_NORMAL   = 4'h0;
    localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
    localparam logic [3:0] MODE_PFC_CAPT = 4'h8;
    localparam logic [3:0] MODE_PC_CAPT  = 4'hA;
    localparam logic [3:0] MODE_CTC_CAPT = 4'hC;
    localparam logic [3:0] MODE_FAST_CAPT = 4'hE;

    // Events from one counter unit, all on the core clock except capture_pin
    typedef struct packed {
        logic       capture_pin;
        logic       top_hit;
        logic       cmpa_match;
        logic       cmpb_match;
        logic       force_cmpa;
        logic       force_cmpb;
        logic       overflow;
        logic       mode_ovf;
        logic [3:0] waveform_mode_sel;
    } timer_events_t;

    typedef struct packed {
        logic             wr;
        logic             rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage

// ===== rtl/timer16_irq_mask_flags.sv
// Interrupt flags, masks and requests for the two 16-bit timer instances
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
// How it works
// [R1] Request per source only while enable, global enable and flag are all set.
// [R2] Mask layout: capture enable bit 5, compare B 2, compare A 1, overflow 0.
// [R3] Bits 7:6 and 4:3 of mask and flag registers always read zero.
// [R4] Flag layout: capture bit 5, compare B 2, compare A 1, overflow 0; reset zero.
// [R5] Capture flag sets on a capture edge at the timer's capture pin.
// [R6] With capture register as top, capture flag sets when counter hits top.
// [R7] Compare flag sets in the cycle after counter equals the compare value.
// [R8] A forced compare strobe never sets a compare flag.
// [R9] Overflow flag sets on overflow in normal/CTC, else per-mode counter event.
// [R10] Vector acknowledge from the core clears that source's flag.
// [R11] Writing one to a flag bit clears that flag.
// [R12] Writing zero leaves a flag alone; a hardware set beats a software clear.
// [R13] Masks are plain read/write storage resetting to zero; two identical instances.
module timer16_irq_mask_flags
    import timer_irq_pkg::*;
#(
    parameter int N_TIMERS = NUM_TIMERS
) (
    input  wire logic                            i_core_clk,
    input  wire logic                            i_reset_n,
    input  wire reg_req_t                        i_reg,
    output logic      [DATA_W-1:0]               o_rdata,
    input  wire timer_events_t [N_TIMERS-1:0]    i_events,
    input  wire logic [N_TIMERS-1:0][DATA_W-1:0] i_vector_ack,
    input  wire logic                            i_global_irq_en,
    output logic      [N_TIMERS-1:0][DATA_W-1:0] o_irq_req,
    output logic      [N_TIMERS-1:0][1:0]        o_cmp_strobe,
    output logic                                 o_irq
);

    logic                    rst_meta;
    logic                    rst_n;
    logic [DATA_W-1:0]       flags      [N_TIMERS];
    logic [DATA_W-1:0]       mask       [N_TIMERS];
    logic [DATA_W-1:0]       hw_set     [N_TIMERS];
    logic [DATA_W-1:0]       sw_clr     [N_TIMERS];
    logic [N_TIMERS-1:0]     capt_top   ;
    logic [N_TIMERS-1:0]     capt_edge  ;
    logic [N_TIMERS-1:0]     ovf_plain  ;
    logic [N_TIMERS-1:0]     any_pend   ;

    // Reset released through two flops so every flop leaves reset together
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!rst_n);

    for (genvar t = 0; t < N_TIMERS; t++) begin : g_timer
        logic cap_meta;
        logic cap_sync;
        logic cap_prev;
        logic [3:0] mode;

        assign mode = i_events[t].waveform_mode_sel;

        // Pin is asynchronous; only cap_sync and later are looked at
        always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
                cap_meta <= 1'b0;
                cap_sync <= 1'b0;
                cap_prev <= 1'b0;
            end else begin
                cap_meta <= i_events[t].capture_pin;
                cap_sync <= cap_meta;
                cap_prev <= cap_sync;
            end
        end

        assign capt_edge[t] = cap_sync & ~cap_prev;

        assign capt_top[t] = (mode == MODE_PFC_CAPT) || (mode == MODE_PC_CAPT) ||
                             (mode == MODE_CTC_CAPT) || (mode == MODE_FAST_CAPT);

        assign ovf_plain[t] = (mode == MODE_NORMAL) || (mode == MODE_CTC_CMPA) ||
                              (mode == MODE_CTC_CAPT);

        // Forced compare strobes deliberately absent from the set terms
        always_comb begin
            hw_set[t] = '0;
            hw_set[t][BIT_CAPTURE] = capt_top[t] ? i_events[t].top_hit  // [R6]
                                                 : capt_edge[t];        // [R5]
            hw_set[t][BIT_CMPA] = i_events[t].cmpa_match;               // [R7] [R8]
            hw_set[t][BIT_CMPB] = i_events[t].cmpb_match;               // [R7] [R8]
            hw_set[t][BIT_OVF]  = ovf_plain[t] ? i_events[t].overflow   // [R9]
                                               : i_events[t].mode_ovf;
        end

        assign sw_clr[t] = (i_reg.wr && i_reg.addr == FLAGS_ADDR[t]) ? i_reg.wdata : '0;

        // Set wins over both clears; zeros written leave bits alone
        always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
                flags[t] <= FLAGS_RESET;                                // [R4]
            end else begin
                flags[t] <= ((flags[t] & ~(sw_clr[t] | i_vector_ack[t])) // [R10] [R11]
                             | hw_set[t]) & IMPL_BITS;                  // [R12] [R3]
            end
        end

        always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
                mask[t] <= MASK_RESET;                                  // [R13]
            end else if (i_reg.wr && i_reg.addr == MASK_ADDR[t]) begin
                mask[t] <= i_reg.wdata & IMPL_BITS;                     // [R2] [R3]
            end
        end

        // Registered request costs one cycle but keeps outputs glitch free
        always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
                o_irq_req[t] <= '0;
            end else begin
                o_irq_req[t] <= mask[t] & flags[t] & {DATA_W{i_global_irq_en}}; // [R1]
            end
        end

        assign any_pend[t] = |(mask[t] & flags[t]);

        // Waveform unit still sees forced strobes
        always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
                o_cmp_strobe[t] <= '0;
            end else begin
                o_cmp_strobe[t] <= {i_events[t].cmpb_match | i_events[t].force_cmpb,
                                    i_events[t].cmpa_match | i_events[t].force_cmpa};
            end
        end

        a_reserved_zero: assert property ( // [R3]
            ((flags[t] | mask[t]) & ~IMPL_BITS) == '0)
            else $error("reserved bit set");

        a_req_needs_all: assert property ( // [R1]
            o_irq_req[t] != '0 |->
                (o_irq_req[t] & ~($past(mask[t] & flags[t]))) == '0 &&
                $past(i_global_irq_en))
            else $error("request without enable, flag and global enable");

        a_req_follows: assert property ( // [R1]
            (i_global_irq_en && (mask[t] & flags[t]) != '0) |=> o_irq_req[t] != '0)
            else $error("enabled flag raised no request");

        a_cmp_next: assert property ( // [R7]
            i_events[t].cmpa_match |=> flags[t][BIT_CMPA])
            else $error("compare A match did not set flag next cycle");

        a_cmpb_next: assert property ( // [R7]
            i_events[t].cmpb_match |=> flags[t][BIT_CMPB])
            else $error("compare B match did not set flag next cycle");

        a_force_no_flag: assert property ( // [R8]
            (i_events[t].force_cmpa && !i_events[t].cmpa_match && !flags[t][BIT_CMPA])
                |=> !flags[t][BIT_CMPA] && o_cmp_strobe[t][0])
            else $error("forced compare set a flag");

        a_capture_pin: assert property ( // [R5]
            (!capt_top[t] && $rose(cap_sync)) |=> flags[t][BIT_CAPTURE])
            else $error("capture edge did not set flag");

        a_capture_top: assert property ( // [R6]
            (capt_top[t] && i_events[t].top_hit) |=> flags[t][BIT_CAPTURE])
            else $error("top hit did not set capture flag");

        a_capture_top_only: assert property ( // [R6]
            (capt_top[t] && !i_events[t].top_hit && !flags[t][BIT_CAPTURE])
                |=> !flags[t][BIT_CAPTURE])
            else $error("capture flag set without top hit");

        a_ovf_modes: assert property ( // [R9]
            ((ovf_plain[t] && i_events[t].overflow) ||
             (!ovf_plain[t] && i_events[t].mode_ovf)) |=> flags[t][BIT_OVF])
            else $error("overflow event did not set flag");

        a_ack_clears: assert property ( // [R10]
            (i_vector_ack[t] & ~hw_set[t]) != '0 |=>
                (flags[t] & $past(i_vector_ack[t] & ~hw_set[t])) == '0)
            else $error("acknowledge left flag set");

        a_write_clears: assert property ( // [R11]
            sw_clr[t] != '0 |=> (flags[t] & $past(sw_clr[t] & ~hw_set[t])) == '0)
            else $error("write of one left flag set");

        a_zero_keeps: assert property ( // [R12]
            1'b1 |=> ($past(flags[t] & ~(sw_clr[t] | i_vector_ack[t])) & ~flags[t]) == '0)
            else $error("flag lost without a clear");

        a_set_wins: assert property ( // [R12]
            (hw_set[t] & sw_clr[t]) != '0 |=> (flags[t] & $past(hw_set[t])) ==
                $past(hw_set[t])) 
            else $error("software clear beat hardware set");

        a_mask_store: assert property ( // [R13]
            (i_reg.wr && i_reg.addr == MASK_ADDR[t]) |=>
                mask[t] == $past(i_reg.wdata & IMPL_BITS) ##1
                (mask[t] == $past(mask[t]) || $past(i_reg.wr)))
            else $error("mask write not stored or not held");

        a_mask_bits: assert property ( // [R2]
            (i_reg.wr && i_reg.addr == MASK_ADDR[t]) |=>
                mask[t][BIT_CAPTURE] == $past(i_reg.wdata[5]) &&
                mask[t][BIT_CMPB] == $past(i_reg.wdata[2]) &&
                mask[t][BIT_CMPA] == $past(i_reg.wdata[1]) &&
                mask[t][BIT_OVF] == $past(i_reg.wdata[0]))
            else $error("mask bit in wrong position");

        // Forced strobes reach the waveform side but never a flag
        a_cmpb_force: assert property ( // [R8]
            (i_events[t].force_cmpb && !i_events[t].cmpb_match && !flags[t][BIT_CMPB])
                |=> !flags[t][BIT_CMPB] && o_cmp_strobe[t][1])
            else $error("forced compare B set a flag");

        a_strobe_a: assert property ( // [R8]
            (i_events[t].cmpa_match || i_events[t].force_cmpa) |=> o_cmp_strobe[t][0])
            else $error("compare A strobe missing");

        a_strobe_b: assert property ( // [R8]
            (i_events[t].cmpb_match || i_events[t].force_cmpb) |=> o_cmp_strobe[t][1])
            else $error("compare B strobe missing");

        a_strobe_quiet: assert property ( // [R8]
            !(i_events[t].cmpa_match || i_events[t].force_cmpa ||
              i_events[t].cmpb_match || i_events[t].force_cmpb)
                |=> o_cmp_strobe[t] == 2'h0)
            else $error("compare strobe without match or force");

        // Flags may rise only through a hardware set term
        a_no_stray_set: assert property ( // [R8]
            1'b1 |=> (flags[t] & ~$past(flags[t] | hw_set[t])) == '0)
            else $error("flag set with no event");

        a_cmpa_only: assert property ( // [R7]
            (!i_events[t].cmpa_match && !flags[t][BIT_CMPA]) |=> !flags[t][BIT_CMPA])
            else $error("compare A flag set without match");

        a_cmpb_only: assert property ( // [R7]
            (!i_events[t].cmpb_match && !flags[t][BIT_CMPB]) |=> !flags[t][BIT_CMPB])
            else $error("compare B flag set without match");

        a_capture_pin_only: assert property ( // [R5]
            (!capt_top[t] && !capt_edge[t] && !flags[t][BIT_CAPTURE])
                |=> !flags[t][BIT_CAPTURE])
            else $error("capture flag set without pin edge");

        a_ovf_plain_only: assert property ( // [R9]
            (ovf_plain[t] && !i_events[t].overflow && !flags[t][BIT_OVF])
                |=> !flags[t][BIT_OVF])
            else $error("overflow flag set without overflow");

        a_ovf_mode_only: assert property ( // [R9]
            (!ovf_plain[t] && !i_events[t].mode_ovf && !flags[t][BIT_OVF])
                |=> !flags[t][BIT_OVF])
            else $error("overflow flag set without mode event");

        a_ack_set_wins: assert property ( // [R12]
            (hw_set[t] & i_vector_ack[t]) != '0 |=>
                (flags[t] & $past(hw_set[t])) == $past(hw_set[t]))
            else $error("acknowledge beat hardware set");

        a_mask_hold: assert property ( // [R13]
            !(i_reg.wr && i_reg.addr == MASK_ADDR[t]) |=> mask[t] == $past(mask[t]))
            else $error("mask changed without a write");

        // Writes elsewhere never take a flag away
        a_write_other: assert property ( // [R13]
            (i_reg.wr && i_reg.addr != FLAGS_ADDR[t] && i_vector_ack[t] == '0) |=>
                (flags[t] & $past(flags[t])) == $past(flags[t]))
            else $error("foreign write cleared a flag");

        // Global enable low must silence every request of this timer
        a_req_gie_off: assert property ( // [R1]
            !i_global_irq_en |=> o_irq_req[t] == '0)
            else $error("request while globally disabled");

        a_req_level: assert property ( // [R1]
            (i_global_irq_en && (mask[t] & flags[t]) != '0) |=>
                o_irq_req[t] == $past(mask[t] & flags[t]))
            else $error("request bits differ from enabled flags");

        a_req_in_irq: assert property ( // [R1]
            o_irq_req[t] != '0 |-> o_irq)
            else $error("request without summary line");

        a_read_flag_t: assert property ( // [R4]
            (i_reg.rd && i_reg.addr == FLAGS_ADDR[t]) |=> o_rdata == $past(flags[t]))
            else $error("flag register read wrong");

        a_read_mask_t: assert property ( // [R2]
            (i_reg.rd && i_reg.addr == MASK_ADDR[t]) |=> o_rdata == $past(mask[t]))
            else $error("mask register read wrong");
    end

    // Read data valid in the single cycle after the read strobe
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= RDATA_IDLE;
        end else begin
            o_rdata <= RDATA_IDLE;
            for (int t = 0; t < N_TIMERS; t++) begin
                if (i_reg.rd && i_reg.addr == FLAGS_ADDR[t]) begin
                    o_rdata <= flags[t];                                // [R4]
                end
                if (i_reg.rd && i_reg.addr == MASK_ADDR[t]) begin
                    o_rdata <= mask[t];                                 // [R2]
                end
            end
        end
    end

    // Summary line ignores the global enable so software can poll it
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |any_pend;
        end
    end

    a_read_flags: assert property ( // [R4]
        (i_reg.rd && i_reg.addr == FLAGS_ADDR[0]) |=> o_rdata == $past(flags[0]))
        else $error("flag read returned wrong value");

    a_irq_level: assert property (
        (|any_pend) |=> o_irq)
        else $error("interrupt line low with pending source");

    a_rdata_idle: assert property ( // [R3]
        !i_reg.rd |=> o_rdata == RDATA_IDLE)
        else $error("read data outside the read cycle");

    a_irq_quiet: assert property (
        !(|any_pend) |=> !o_irq)
        else $error("interrupt line high with nothing pending");

endmodule

// ===== verif/core_ack_model.sv
// Core-side model that acknowledges every pending request once
`timescale 1ns/10ps
module core_ack_model (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_enable,
    input  wire logic [1:0][7:0]       i_irq_req,
    output logic      [1:0][7:0]       o_vector_ack
);
    logic [1:0][7:0] ack_held;

    // A request lingers two cycles after its acknowledge, so hold off for both
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_vector_ack <= '0;
            ack_held     <= '0;
        end else begin
            ack_held <= o_vector_ack;
            for (int t = 0; t < 2; t++) begin
                o_vector_ack[t] <= i_enable ? (i_irq_req[t] & ~o_vector_ack[t] & ~ack_held[t])
                                            : 8'h00;
            end
        end
    end
endmodule

// ===== verif/tb_top.sv
// Register and event sequences for the timer interrupt flag and mask block
`timescale 1ns/10ps
module tb_top
    import timer_irq_pkg::*;
();
    logic                  clk     = 1'b0;
    logic                  rst_n   = 1'b1;
    reg_req_t              req     = '0;
    timer_events_t [1:0]   ev      = '0;
    logic                  gie     = 1'b0;
    logic                  ack_en  = 1'b0;
    logic [1:0][7:0]       ack;
    logic [1:0][7:0]       irq_req;
    logic [1:0][1:0]       cmp_strobe;
    logic [7:0]            rdata;
    logic                  irq;
    int                    n_mismatch = 0;
    int                    n_checks   = 0;

    timer16_irq_mask_flags dut (
        .i_core_clk      (clk),
        .i_reset_n       (rst_n),
        .i_reg           (req),
        .o_rdata         (rdata),
        .i_events        (ev),
        .i_vector_ack    (ack),
        .i_global_irq_en (gie),
        .o_irq_req       (irq_req),
        .o_cmp_strobe    (cmp_strobe),
        .o_irq           (irq)
    );

    core_ack_model core (
        .i_core_clk   (clk),
        .i_reset_n    (rst_n),
        .i_enable     (ack_en),
        .i_irq_req    (irq_req),
        .o_vector_ack (ack)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d, checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        check(rdata, exp);
    endtask

    // Capture pin needs sync plus edge detect, so settle six cycles
    task automatic ev_pulse(input int t, input int b);
        @(posedge clk);
        ev[t][b] <= 1'b1;
        @(posedge clk);
        ev[t][b] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    // Strobe output stands one cycle only, so look right after its launching edge
    task automatic strobe_pulse(input int t, input int b, input logic [1:0] exp);
        @(posedge clk);
        ev[t][b] <= 1'b1;
        @(posedge clk);
        ev[t][b] <= 1'b0;
        #1;
        check({6'h00, cmp_strobe[t]}, {6'h00, exp});
        @(posedge clk);
        #1;
        check({6'h00, cmp_strobe[t]}, 8'h00);
    endtask

    task automatic settle_and_check(input int t, input logic [7:0] exp);
        repeat (3) @(posedge clk);
        #1;
        check(irq_req[t], exp);
    endtask

    initial begin
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int t = 0; t < 2; t++) begin
            rd(FLAGS_ADDR[t], 8'h00);
            rd(MASK_ADDR[t], 8'h00);
            wr(MASK_ADDR[t], 8'hFF);
            rd(MASK_ADDR[t], 8'h27);
            wr(MASK_ADDR[t], 8'h00);
            rd(MASK_ADDR[t], 8'h00);
        end
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        for (int t = 0; t < 2; t++) begin
            ev[t].waveform_mode_sel <= MODE_NORMAL;
            strobe_pulse(t, 7, 2'h1);
            strobe_pulse(t, 6, 2'h2);
            rd(FLAGS_ADDR[t], 8'h00);
            ev_pulse(t, 9);
            rd(FLAGS_ADDR[t], 8'h02);
            ev_pulse(t, 8);
            rd(FLAGS_ADDR[t], 8'h06);
            ev_pulse(t, 5);
            rd(FLAGS_ADDR[t], 8'h07);
            ev_pulse(t, 11);
            rd(FLAGS_ADDR[t], 8'h27);
            rd(FLAGS_ADDR[1 - t], 8'h00);
            wr(FLAGS_ADDR[t], 8'h00);
            rd(FLAGS_ADDR[t], 8'h27);
            wr(FLAGS_ADDR[t], 8'h02);
            rd(FLAGS_ADDR[t], 8'h25);
            @(posedge clk);
            req <= '{wr: 1'b1, rd: 1'b0, addr: FLAGS_ADDR[t], wdata: 8'hFF};
            ev[t].cmpa_match <= 1'b1;
            @(posedge clk);
            req <= '0;
            ev[t].cmpa_match <= 1'b0;
            rd(FLAGS_ADDR[t], 8'h02);
            wr(FLAGS_ADDR[t], 8'h02);
            rd(FLAGS_ADDR[t], 8'h00);
            ev[t].waveform_mode_sel <= MODE_CTC_CAPT;
            ev_pulse(t, 10);
            rd(FLAGS_ADDR[t], 8'h20);
            ev[t].waveform_mode_sel <= MODE_PFC_CAPT;
            ev_pulse(t, 5);
            rd(FLAGS_ADDR[t], 8'h20);
            ev_pulse(t, 4);
            rd(FLAGS_ADDR[t], 8'h21);
            wr(MASK_ADDR[t], 8'h01);
            gie <= 1'b1;
            settle_and_check(t, 8'h01);
            check({7'h00, irq}, 8'h01);
            gie <= 1'b0;
            settle_and_check(t, 8'h00);
            check({7'h00, irq}, 8'h01);
            gie <= 1'b1;
            ack_en <= 1'b1;
            repeat (6) @(posedge clk);
            ack_en <= 1'b0;
            rd(FLAGS_ADDR[t], 8'h20);
            settle_and_check(t, 8'h00);
            check({7'h00, irq}, 8'h00);
            gie <= 1'b0;
            wr(FLAGS_ADDR[t], 8'hFF);
            wr(MASK_ADDR[t], 8'h00);
            ev[t].waveform_mode_sel <= MODE_CTC_CMPA;
            ev_pulse(t, 5);
            rd(FLAGS_ADDR[t], 8'h01);
            ev[t].waveform_mode_sel <= MODE_PC_CAPT;
            ev_pulse(t, 11);
            rd(FLAGS_ADDR[t], 8'h01);
            ev[t].waveform_mode_sel <= MODE_FAST_CAPT;
            ev_pulse(t, 10);
            rd(FLAGS_ADDR[t], 8'h21);
            wr(FLAGS_ADDR[t], 8'hFF);
            ev[t].waveform_mode_sel <= MODE_NORMAL;
        end
        ev_pulse(0, 5);
        wr(MASK_ADDR[0], 8'h01);
        // Mid-run reset must drop flags, masks and the summary line
        @(posedge clk);
        #1;
        check({7'h00, irq}, 8'h01);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(FLAGS_ADDR[0], 8'h00);
        rd(MASK_ADDR[0], 8'h00);
        check({7'h00, irq}, 8'h00);
        tally_and_finish();
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
